//--- core/cpw_engine.sv
`timescale 1ns/1ps
module cpw_engine (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire cpw_pkg::cpw_addr_t ADDR,
	input wire cpw_pkg::cpw_cnt_t WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	output logic [2:0] PWM_POS,
	output logic [2:0] PWM_NEG
);
	import cpw_pkg::*;

	cpw_state_e state_q;
	logic [3:0] mode_q;
	logic [2:0] positive_level_select_q;
	logic [2:0] negative_level_select_q;
	cpw_cnt_t ulbuf_q, cycbuf_q, dead_q;
	cpw_cnt_t dbuf_q [3];
	cpw_cnt_t ultmp_q, cyctmp_q;
	cpw_cnt_t dtmp_q [3];
	cpw_cnt_t ulim_q, cyc_q;
	cpw_cnt_t dcmp_q [3];
	cpw_cnt_t cnt1_q, cnt2_q, sub_q;
	logic down_q;
	logic sub_run_q;
	logic sub_down_q;
	logic pend_q;
	logic live_q;
	logic [2:0] pos_q, neg_q, arm_q;
	logic [2:0] neg_arm_q;

	logic wr_mode, enter, leave, run, crest, trough, xfer_pt, tmp_load;
	assign wr_mode = WR && (ADDR == A_MODE);
	assign enter = wr_mode && (WDATA[3:0] >= MODE_CREST) && (state_q == ST_OFF);
	assign leave = wr_mode && (WDATA[3:0] < MODE_CREST);
	assign run = (state_q == ST_RUN);
	assign crest = run && !down_q && (cnt1_q == ulim_q);
	assign trough = run && down_q && (cnt2_q == CNT_ZERO);
	// update point select
	assign xfer_pt = (crest && (mode_q == MODE_CREST || mode_q == MODE_BOTH)) ||
		(trough && (mode_q == MODE_TROUGH || mode_q == MODE_BOTH));
	assign tmp_load = pend_q && !sub_run_q;

	// mode state
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= ST_OFF;
		end else if (leave) begin
			state_q <= ST_OFF;
		end else begin
			unique case (state_q)
				ST_OFF: begin
					if (enter) state_q <= ST_READY;
				end
				ST_READY: begin
					if (WR && ADDR == A_START && WDATA[0]) state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (WR && ADDR == A_START && !WDATA[0]) state_q <= ST_READY;
				end
			endcase
		end
	end

	// control registers
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_q <= MODE_NORMAL;
			positive_level_select_q <= OLS_RST[2:0];
			negative_level_select_q <= OLS_RST[5:3];
			dead_q <= REG_RST;
		end else begin
			if (wr_mode) mode_q <= WDATA[3:0];
			// levels and dead time frozen while the mode is on
			if (WR && ADDR == A_OUTCTL && state_q == ST_OFF) begin
				positive_level_select_q <= WDATA[2:0];
				negative_level_select_q <= WDATA[5:3];
			end
			if (WR && ADDR == A_DEAD && state_q == ST_OFF) dead_q <= WDATA;
		end
	end

	// buffers, always writable
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ulbuf_q <= REG_RST;
			cycbuf_q <= REG_RST;
		end else if (WR) begin
			if (ADDR == A_ULBUF) ulbuf_q <= WDATA;
			if (ADDR == A_CYCBUF) cycbuf_q <= WDATA;
		end
	end

	// pending buffer-to-temporary move, armed by the third duty write
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pend_q <= 1'b0;
		end else if (WR && ADDR == A_DUTY3) begin
			pend_q <= 1'b1;
		end else if (tmp_load) begin
			pend_q <= 1'b0;
		end
	end

	// limit and cycle temporaries and compares
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ultmp_q <= REG_RST;
			cyctmp_q <= REG_RST;
			ulim_q <= REG_RST;
			cyc_q <= REG_RST;
		end else begin
			if (tmp_load) begin
				ultmp_q <= ulbuf_q;
				cyctmp_q <= cycbuf_q;
			end
			if (enter) begin
				ulim_q <= ulbuf_q;
				cyc_q <= cycbuf_q;
			end else if (xfer_pt) begin
				ulim_q <= ultmp_q;
				cyc_q <= cyctmp_q;
			end
		end
	end

	// per-phase duty storage and waveform
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_ph
			cpw_addr_t dadr;
			logic hit1, hit2;
			assign dadr = A_DUTY1 + cpw_addr_t'(p);
			// match on compare, and on temporary while subcounter counts
			assign hit1 = run && live_q && ((cnt1_q == dcmp_q[p]) ||
				(sub_run_q && cnt1_q == dtmp_q[p]));
			assign hit2 = run && live_q && ((cnt2_q == dcmp_q[p]) ||
				(sub_run_q && cnt2_q == dtmp_q[p]));

			always_ff @(posedge CORE_CLK or negedge RST_B) begin
				if (!RST_B) begin
					dbuf_q[p] <= REG_RST;
					dtmp_q[p] <= REG_RST;
					dcmp_q[p] <= REG_RST;
				end else begin
					if (WR && ADDR == dadr) dbuf_q[p] <= WDATA;
					if (tmp_load) dtmp_q[p] <= dbuf_q[p];
					if (enter) begin
						dcmp_q[p] <= dbuf_q[p];
					end else if (xfer_pt) begin
						dcmp_q[p] <= dtmp_q[p];
					end
				end
			end

			// off matches arm the opposite turn-on; half change discards stale arms
			always_ff @(posedge CORE_CLK or negedge RST_B) begin
				if (!RST_B) begin
					pos_q[p] <= 1'b0;
					neg_q[p] <= 1'b0;
					arm_q[p] <= 1'b0;
					neg_arm_q[p] <= 1'b0;
				end else if (!run || !live_q) begin
					pos_q[p] <= 1'b0;
					neg_q[p] <= 1'b0;
					arm_q[p] <= 1'b0;
					neg_arm_q[p] <= 1'b0;
				end else if (crest || trough) begin
					arm_q[p] <= 1'b0;
					neg_arm_q[p] <= 1'b0;
				end else if (!down_q) begin
					// first half: first counter leads, negative off wins, then positive on
					if (hit1) begin
						neg_q[p] <= 1'b0;
						arm_q[p] <= 1'b1;
					end else if (hit2 && arm_q[p] && !neg_q[p]) begin
						pos_q[p] <= 1'b1;
						arm_q[p] <= 1'b0;
					end
				end else begin
					// second half: second counter leads on the way down, so it turns off
					if (hit2) begin
						pos_q[p] <= 1'b0;
						arm_q[p] <= 1'b0;
						neg_arm_q[p] <= 1'b1;
					end else if (hit1 && neg_arm_q[p] && !pos_q[p]) begin
						neg_q[p] <= 1'b1;
						neg_arm_q[p] <= 1'b0;
					end
				end
			end

			// selected active level, both outputs driven low while the mode is off
			always_ff @(posedge CORE_CLK or negedge RST_B) begin
				if (!RST_B) begin
					PWM_POS[p] <= 1'b0;
					PWM_NEG[p] <= 1'b0;
				end else if (state_q == ST_OFF) begin
					PWM_POS[p] <= 1'b0;
					PWM_NEG[p] <= 1'b0;
				end else begin
					PWM_POS[p] <= pos_q[p] ? positive_level_select_q[p] : ~positive_level_select_q[p];
					PWM_NEG[p] <= neg_q[p] ? negative_level_select_q[p] : ~negative_level_select_q[p];
				end
			end
		end
	endgenerate

	// main counters
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt1_q <= CNT_ZERO;
			cnt2_q <= CNT_ZERO;
			down_q <= 1'b0;
		end else if (enter) begin
			cnt1_q <= dead_q;
			down_q <= 1'b0;
		end else if (WR && ADDR == A_CNT2 && !run) begin
			cnt2_q <= WDATA;
		end else if (run) begin
			if (crest) begin
				down_q <= 1'b1;
				cnt1_q <= cnt1_q - 16'h0001;
				cnt2_q <= cnt2_q - 16'h0001;
			end else if (trough) begin
				down_q <= 1'b0;
				cnt1_q <= cnt1_q + 16'h0001;
				cnt2_q <= cnt2_q + 16'h0001;
			end else if (down_q) begin
				cnt1_q <= cnt1_q - 16'h0001;
				cnt2_q <= (cnt2_q == CNT_ZERO) ? CNT_ZERO : cnt2_q - 16'h0001;
			end else begin
				cnt1_q <= cnt1_q + 16'h0001;
				cnt2_q <= (cnt2_q == cyc_q) ? cnt2_q : cnt2_q + 16'h0001;
			end
		end
	end

	// outputs released once the second counter passes the dead time
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			live_q <= 1'b0;
		end else if (enter || state_q == ST_OFF) begin
			live_q <= 1'b0;
		end else if (run && cnt2_q > dead_q) begin
			live_q <= 1'b1;
		end
	end

	// subcounter mirrors the counters through each dead-time window, then halts
	// so that pending temporaries can load between windows
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sub_q <= CNT_ZERO;
			sub_run_q <= 1'b0;
			sub_down_q <= 1'b0;
		end else if (!run) begin
			sub_run_q <= 1'b0;
		end else if (!sub_run_q) begin
			if (!down_q && cnt1_q == cyc_q) begin
				sub_run_q <= 1'b1;
				sub_down_q <= 1'b1;
				sub_q <= ulim_q;
			end else if (down_q && cnt2_q == dead_q) begin
				sub_run_q <= 1'b1;
				sub_down_q <= 1'b0;
				sub_q <= CNT_ZERO;
			end
		end else if (sub_down_q) begin
			if (sub_q == CNT_ZERO) begin
				sub_q <= ulim_q; // trough window done
				sub_run_q <= 1'b0;
			end else if (sub_q == cyc_q) begin
				sub_down_q <= 1'b0; // crest window turns back up
			end else begin
				sub_q <= sub_q - 16'h0001;
			end
		end else begin
			if (sub_q == ulim_q) begin
				sub_q <= CNT_ZERO; // crest window done
				sub_run_q <= 1'b0;
			end else if (sub_q == dead_q) begin
				sub_down_q <= 1'b1;
			end else begin
				sub_q <= sub_q + 16'h0001;
			end
		end
	end

	// register read, data in the cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= CNT_ZERO;
		end else if (RD) begin
			unique case (ADDR)
				A_MODE: RDATA <= {12'h000, mode_q};
				A_OUTCTL: RDATA <= {10'h000, negative_level_select_q, positive_level_select_q};
				A_START: RDATA <= {15'h0000, run};
				A_ULBUF: RDATA <= ulbuf_q;
				A_CYCBUF: RDATA <= cycbuf_q;
				A_DEAD: RDATA <= dead_q;
				A_DUTY1: RDATA <= dbuf_q[0];
				A_DUTY2: RDATA <= dbuf_q[1];
				A_DUTY3: RDATA <= dbuf_q[2];
				A_CNT1: RDATA <= cnt1_q;
				A_CNT2: RDATA <= cnt2_q;
				A_SUB: RDATA <= sub_q;
				A_ULIM: RDATA <= ulim_q;
				A_CYC: RDATA <= cyc_q;
				A_CMP1: RDATA <= dcmp_q[0];
				A_CMP2: RDATA <= dcmp_q[1];
				A_CMP3: RDATA <= dcmp_q[2];
				A_STAT: RDATA <= {12'h000, live_q, pend_q, sub_run_q, down_q};
				default: RDATA <= CNT_ZERO;
			endcase
		end else begin
			RDATA <= CNT_ZERO;
		end
	end
endmodule // cpw_engine

//--- include/cpw_pkg.sv
// Contract
// - entering the mode copies five buffers into compare registers at once
// - first counter starts from the dead time value
// - upper limit and cycle data load together at the selected transfer point
// - crest-loaded cycle acts next cycle, trough-loaded cycle acts this cycle
// - buffers always writable; temporaries update only while subcounter idle
// - temporaries move to compares at crest, trough or both per mode
// - third-phase duty write moves all five buffers to temporaries together
// - outputs inactive from mode entry until second counter exceeds dead time
// - matches drive selected level; temporaries also compared while subcounter counts
// - off timing from leading counter, on timing from lagging counter
// - first half negative-off match wins, second half positive-off match wins
// - positive-off before pending positive-on discards the turn-on
// - opposite phase stays off when an off interval is under two dead times
// - turn-on matches before the governing turn-off match are ignored
// - first counter counts up to upper limit then down to dead time
// - second counter reverses at cycle data and at zero
package cpw_pkg;
	localparam int CW = 16;
	localparam int AW = 5;
	typedef logic [CW-1:0] cpw_cnt_t;
	typedef logic [AW-1:0] cpw_addr_t;
	// register offsets
	localparam cpw_addr_t A_MODE = 5'h00;
	localparam cpw_addr_t A_OUTCTL = 5'h01;
	localparam cpw_addr_t A_START = 5'h02;
	localparam cpw_addr_t A_ULBUF = 5'h03;
	localparam cpw_addr_t A_CYCBUF = 5'h04;
	localparam cpw_addr_t A_DEAD = 5'h05;
	localparam cpw_addr_t A_DUTY1 = 5'h06;
	localparam cpw_addr_t A_DUTY2 = 5'h07;
	localparam cpw_addr_t A_DUTY3 = 5'h08;
	localparam cpw_addr_t A_CNT1 = 5'h09;
	localparam cpw_addr_t A_CNT2 = 5'h0A;
	localparam cpw_addr_t A_SUB = 5'h0B;
	localparam cpw_addr_t A_ULIM = 5'h0C;
	localparam cpw_addr_t A_CYC = 5'h0D;
	localparam cpw_addr_t A_CMP1 = 5'h0E;
	localparam cpw_addr_t A_CMP2 = 5'h0F;
	localparam cpw_addr_t A_CMP3 = 5'h10;
	localparam cpw_addr_t A_STAT = 5'h11;
	// mode field codes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CREST = 4'hD;
	localparam logic [3:0] MODE_TROUGH = 4'hE;
	localparam logic [3:0] MODE_BOTH = 4'hF;
	// reset values
	localparam cpw_cnt_t CNT_ZERO = 16'h0000;
	localparam cpw_cnt_t REG_RST = 16'hFFFF;
	localparam logic [5:0] OLS_RST = 6'h00;
	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_READY = 3'b010,
		ST_RUN = 3'b100
	} cpw_state_e;
endpackage

//--- bench/cpw_gate_model.sv
`timescale 1ns/1ps
module cpw_gate_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic armed,
	input wire logic [5:0] ols,
	input wire logic [2:0] pos,
	input wire logic [2:0] neg,
	output logic [15:0] fault_cnt,
	output logic [5:0] seen_on
);
	logic [2:0] on_p, on_n;
	assign on_p = ~(pos ^ ols[2:0]);
	assign on_n = ~(neg ^ ols[5:3]);
	// both gates of a leg on together would short the bridge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) fault_cnt <= 16'h0000;
		else if (armed && |(on_p & on_n)) fault_cnt <= fault_cnt + 16'h0001;
	end
	// remembers which gates were ever switched on while armed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) seen_on <= 6'h00;
		else seen_on <= armed ? (seen_on | {on_n, on_p}) : 6'h00;
	end
endmodule // cpw_gate_model

//--- bench/cpw_engine_props.sv
`timescale 1ns/1ps
module cpw_engine_props (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire cpw_pkg::cpw_addr_t ADDR,
	input wire cpw_pkg::cpw_cnt_t WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic [2:0] PWM_POS,
	input wire logic [2:0] PWM_NEG
);
	import cpw_pkg::*;
	logic mode_q;
	logic [5:0] ols_q;
	cpw_cnt_t dead_q;
	logic dead_ok_q;
	logic [2:0] act_p, act_n;
	assign act_p = ~(PWM_POS ^ ols_q[2:0]);
	assign act_n = ~(PWM_NEG ^ ols_q[5:3]);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	// mirror of the mode as software set it
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) mode_q <= 1'b0;
		else if (WR && ADDR == A_MODE) mode_q <= (WDATA[3:0] >= MODE_CREST);
	end
	// level and dead time only land while the mode is off
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ols_q <= OLS_RST;
			dead_q <= CNT_ZERO;
			dead_ok_q <= 1'b0;
		end else if (WR && !mode_q) begin
			if (ADDR == A_OUTCTL) ols_q <= WDATA[5:0];
			if (ADDR == A_DEAD) dead_q <= WDATA;
			if (ADDR == A_DEAD) dead_ok_q <= 1'b1;
		end
	end
	no_overlap_a: assert property (mode_q && $past(mode_q, 2) |-> (act_p & act_n) == 3'b000)
		else $error("both gates of a leg active");
	init_idle_a: assert property ($rose(mode_q) |-> ##1 (act_p == 3'b000 && act_n == 3'b000) [*3])
		else $error("output active right after mode entry");
	off_zero_a: assert property (!mode_q && !$past(mode_q) |-> PWM_POS == 3'h0 && PWM_NEG == 3'h0)
		else $error("outputs not low with mode off");
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data outside its slot");
	dead_lock_a: assert property (RD && ADDR == A_DEAD && dead_ok_q |=> RDATA == dead_q)
		else $error("dead time changed in mode");
	level_lock_a: assert property (RD && ADDR == A_OUTCTL |=> RDATA[5:0] == ols_q)
		else $error("level select changed in mode");
	buf_write_a: assert property (WR && ADDR == A_DUTY1 ##2 RD && ADDR == A_DUTY1
		|=> RDATA == $past(WDATA, 3))
		else $error("duty buffer write lost");
	unmapped_a: assert property (RD && ADDR > A_STAT |=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	cover property ($rose(mode_q));
	cover property (mode_q && act_p[0]);
	cover property (mode_q && act_n[0]);
endmodule // cpw_engine_props
bind cpw_engine cpw_engine_props chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PWM_POS(PWM_POS), .PWM_NEG(PWM_NEG));

//--- bench/cpw_engine_bench.sv
`timescale 1ns/1ps
module cpw_engine_bench;
	import cpw_pkg::*;
	logic core_clk, rst_b, wr, rd, armed;
	cpw_addr_t addr;
	cpw_cnt_t wdata, half, dead, d1, d2, d3, nd, got;
	logic [15:0] rdata, fault_cnt;
	logic [2:0] pos, neg;
	logic [5:0] ols, seen_on;
	logic [3:0] codes [3] = '{MODE_CREST, MODE_TROUGH, MODE_BOTH};
	int error_cnt, comparisons, seed, m;
	cpw_engine dut_u (.CORE_CLK(core_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .PWM_POS(pos), .PWM_NEG(neg));
	cpw_gate_model gate_u (.clk(core_clk), .rst_b(rst_b), .armed(armed), .ols(ols), .pos(pos),
		.neg(neg), .fault_cnt(fault_cnt), .seen_on(seen_on));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	function automatic cpw_cnt_t ulim_of(cpw_cnt_t h, cpw_cnt_t d);
		return h + d;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		comparisons++;
		if ((v >= lo && v <= hi) !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: %h outside %h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic wr_reg(input cpw_addr_t a, input cpw_cnt_t d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input cpw_addr_t a);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic rd_chk(input cpw_addr_t a, input logic [15:0] e);
		rd_reg(a);
		chk(got, e);
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// watchdog well beyond three mode passes
	initial begin
		#(20 * 40000);
		error_cnt++;
		wrap_up;
	end
	// main sequence
	initial begin
		seed = 51;
		{error_cnt, comparisons} = '0;
		{rst_b, wr, rd, armed} = 4'h0;
		addr = '0;
		wdata = '0;
		ols = 6'h3F;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		rd_chk(A_DUTY1, REG_RST);
		rd_chk(A_CNT2, CNT_ZERO);
		rd_chk(5'h1F, 16'h0000);
		for (m = 0; m < 3; m++) begin
			half = 16'h0030 + 16'($random(seed) & 16'h000F);
			dead = 16'h0004 + 16'($random(seed) & 16'h0003);
			d1 = dead + 16'h0003 + 16'($random(seed) & 16'h000F);
			d2 = dead + 16'h0003 + 16'($random(seed) & 16'h000F);
			d3 = dead + 16'h0003 + 16'($random(seed) & 16'h000F);
			nd = dead + 16'h0003 + 16'($random(seed) & 16'h000F);
			ols = 6'($random(seed));
			wr_reg(A_OUTCTL, {10'h000, ols});
			wr_reg(A_ULBUF, ulim_of(half, dead));
			wr_reg(A_CYCBUF, half);
			wr_reg(A_DEAD, dead);
			wr_reg(A_DUTY1, d1);
			wr_reg(A_DUTY2, d2);
			wr_reg(A_DUTY3, d3);
			wr_reg(A_CNT2, CNT_ZERO);
			wr_reg(A_MODE, {12'h000, codes[m]});
			rd_chk(A_CMP1, d1);
			rd_chk(A_CMP2, d2);
			rd_chk(A_CMP3, d3);
			rd_chk(A_ULIM, ulim_of(half, dead));
			rd_chk(A_CYC, half);
			rd_chk(A_CNT1, dead);
			wr_reg(A_OUTCTL, {10'h000, ~ols});
			rd_reg(A_OUTCTL);
			chk({10'h000, got[5:0]}, {10'h000, ols});
			wr_reg(A_DEAD, dead + 16'h0001);
			rd_chk(A_DEAD, dead);
			chk({10'h000, neg, pos}, {10'h000, ~ols[5:3], ~ols[2:0]});
			armed <= 1'b1;
			wr_reg(A_START, 16'h0001);
			repeat (20) begin
				rd_reg(A_CNT1);
				in_range(got, dead, ulim_of(half, dead));
				rd_reg(A_CNT2);
				in_range(got, CNT_ZERO, half);
				repeat ($random(seed) & 7) @(posedge core_clk);
			end
			wr_reg(A_DUTY1, nd);
			rd_chk(A_DUTY1, nd);
			wr_reg(A_ULBUF, ulim_of(half + 16'h0002, dead));
			wr_reg(A_CYCBUF, half + 16'h0002);
			repeat (4 * half) @(posedge core_clk);
			rd_chk(A_CMP1, d1);
			wr_reg(A_DUTY3, d3);
			repeat (4 * half + 16) @(posedge core_clk);
			rd_chk(A_CMP1, nd);
			rd_chk(A_CMP3, d3);
			rd_chk(A_ULIM, ulim_of(half + 16'h0002, dead));
			rd_chk(A_CYC, half + 16'h0002);
			chk({10'h000, seen_on}, 16'h003F);
			chk(fault_cnt, 16'h0000);
			armed <= 1'b0;
			wr_reg(A_START, 16'h0000);
			wr_reg(A_MODE, {12'h000, MODE_NORMAL});
			repeat (2) @(posedge core_clk);
			chk({10'h000, neg, pos}, 16'h0000);
		end
		wrap_up;
	end
endmodule // cpw_engine_bench
